//--- verilog/wake_exit_delay_sequencer.sv
// Wake exit delay sequencer: picks and times the delays that follow a wake from Sleep or Idle.
`timescale 1ns/1ps

module wake_exit_delay_sequencer
  import wake_exit_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic sleep_enter_in,
  input wire logic wake_in,
  input wire logic [1:0] prior_source_in,
  input wire logic [2:0] target_mode_in,
  input wire logic freq_sel_write_in,
  input wire logic [2:0] freq_sel_in,
  output logic cpu_run_out,
  output logic startup_timer_done_flag_out,
  output logic internal_osc_stable_flag_out,
  output logic [2:0] internal_osc_freq_sel_out
);

  // ==========================================================================
  // Source decoding.
  // ==========================================================================
  // Crystal and crystal-with-PLL targets are the only ones that need the start-up timer.
  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode == LOW_POWER_CRYSTAL_MODE) || (mode == STANDARD_CRYSTAL_MODE) ||
                 (mode == HIGH_SPEED_CRYSTAL_MODE) || (mode == HIGH_SPEED_CRYSTAL_PLL_MODE);
  endfunction : is_crystal

  // Any internal oscillator frequency, 8 MHz or postscaled, counts alike here.
  function automatic logic is_internal(input logic [2:0] mode);
    is_internal = (mode == INTERNAL_OSC_IO_MODE);
  endfunction : is_internal

  logic wake_from_stopped;
  logic needs_osc_timer;
  logic needs_stabilise;

  always_comb begin
    wake_from_stopped = (prior_source_in == SRC_SECONDARY) ||
                        (prior_source_in == SRC_NONE_SLEEP) ||
                        (prior_source_in == SRC_INTERNAL);
    // Primary idle keeps the primary clock running, so no start-up timer.
    // Non-crystal primary configurations never need the start-up timer.
    needs_osc_timer = wake_from_stopped && is_crystal(target_mode_in);
    needs_stabilise = is_internal(target_mode_in) &&
                      ((prior_source_in == SRC_SECONDARY) ||
                       (prior_source_in == SRC_NONE_SLEEP));
  end

  // ==========================================================================
  // Sequencer state and delay counters.
  // ==========================================================================
  seq_state_t state;
  seq_state_t next_state;
  logic [OSC_COUNT_W-1:0] osc_count;
  logic [OSC_COUNT_W-1:0] next_osc_count;
  logic [PREPARE_COUNT_W-1:0] prepare_count;
  logic [PREPARE_COUNT_W-1:0] next_prepare_count;
  logic cpu_run;
  logic next_cpu_run;
  logic startup_done;
  logic next_startup_done;
  logic wake_take;

  // A wake event is honoured only while the CPU is halted; elsewhere it is dropped.
  always_comb begin
    wake_take = (state == ST_HALTED) && wake_in;
  end

  always_comb begin
    next_state = state;
    next_osc_count = osc_count;
    next_prepare_count = prepare_count;
    next_cpu_run = cpu_run;
    next_startup_done = startup_done;

    case (state)
      ST_RUN: begin
        if (sleep_enter_in) begin
          next_state = ST_HALTED;
          next_cpu_run = 1'b0;
        end
      end
      ST_HALTED: begin
        if (wake_take) begin
          next_state = ST_WAKING;
          next_prepare_count = PREPARE_LOAD;
          if (needs_osc_timer) begin
            next_startup_done = 1'b0;
            if (target_mode_in == HIGH_SPEED_CRYSTAL_PLL_MODE) begin
              next_osc_count = OSC_PLL_LOAD;
            end else begin
              next_osc_count = OSC_ONLY_LOAD;
            end
          end else begin
            next_osc_count = '0;
            next_startup_done = is_crystal(target_mode_in);
          end
        end
      end
      ST_WAKING: begin
        // Both counters tick together, so the wait is the longer one.
        if (prepare_count != '0) begin
          next_prepare_count = prepare_count - PREPARE_COUNT_W'(1);
        end
        if (osc_count != '0) begin
          next_osc_count = osc_count - OSC_COUNT_W'(1);
          if (osc_count == OSC_COUNT_W'(1)) begin
            next_startup_done = 1'b1;
          end
        end
        // Release once every running counter is on its last cycle.
        if ((prepare_count <= PREPARE_COUNT_W'(1)) && (osc_count <= OSC_COUNT_W'(1))) begin
          next_state = ST_RUN;
          next_cpu_run = 1'b1;
        end
      end
      default: begin
        next_state = ST_RUN;
        next_cpu_run = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ST_RUN;
      osc_count <= '0;
      prepare_count <= '0;
      cpu_run <= 1'b1;
      startup_done <= 1'b0;
    end else begin
      state <= next_state;
      osc_count <= next_osc_count;
      prepare_count <= next_prepare_count;
      cpu_run <= next_cpu_run;
      startup_done <= next_startup_done;
    end
  end

  // ==========================================================================
  // Internal oscillator stabilisation.
  // ==========================================================================
  logic [STABILISE_COUNT_W-1:0] stabilise_count;
  logic [STABILISE_COUNT_W-1:0] next_stabilise_count;
  logic osc_stable;
  logic next_osc_stable;

  // Stabilisation runs beside the sequencer and never holds the CPU.
  always_comb begin
    next_stabilise_count = stabilise_count;
    next_osc_stable = osc_stable;
    if (stabilise_count != '0) begin
      next_stabilise_count = stabilise_count - STABILISE_COUNT_W'(1);
      if (stabilise_count == STABILISE_COUNT_W'(1)) begin
        next_osc_stable = 1'b1;
      end
    end
    if (wake_take) begin
      if (needs_stabilise) begin
        next_osc_stable = 1'b0;
        next_stabilise_count = STABILISE_LOAD;
      end else if (is_internal(target_mode_in)) begin
        next_osc_stable = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stabilise_count <= '0;
      osc_stable <= 1'b0;
    end else begin
      stabilise_count <= next_stabilise_count;
      osc_stable <= next_osc_stable;
    end
  end

  // ==========================================================================
  // Internal oscillator frequency selection.
  // ==========================================================================
  logic [2:0] freq_sel;
  logic [2:0] next_freq_sel;

  // A write may land at any time; it does not disturb a wake in progress.
  always_comb begin
    next_freq_sel = freq_sel;
    if (freq_sel_write_in) begin
      next_freq_sel = freq_sel_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      freq_sel <= INTERNAL_OSC_FREQ_1MHZ;
    end else begin
      freq_sel <= next_freq_sel;
    end
  end

  // ==========================================================================
  // Outputs.
  // ==========================================================================
  always_comb begin
    cpu_run_out = cpu_run;
    startup_timer_done_flag_out = startup_done;
    internal_osc_stable_flag_out = osc_stable;
    internal_osc_freq_sel_out = freq_sel;
  end

endmodule : wake_exit_delay_sequencer

//--- verilog/wake_exit_pkg.sv
// Constants, clock-source codes and timing counts for the wake exit delay sequencer.
package wake_exit_pkg;

  // ==========================================================================
  // Clock and delay times.
  // ==========================================================================
  localparam int CLOCK_PERIOD_PS = 25000;
  localparam int CPU_PREPARE_DELAY_NS = 10000;
  localparam int OSC_STARTUP_TIMER_NS = 25600;
  localparam int PLL_LOCK_DELAY_NS = 100000;
  localparam int INTERNAL_OSC_STABILISE_NS = 1000;

  // Least times, so the counts round up to whole cycles.
  localparam int CPU_PREPARE_CYCLES =
    (CPU_PREPARE_DELAY_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int OSC_STARTUP_CYCLES =
    (OSC_STARTUP_TIMER_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int PLL_LOCK_CYCLES =
    (PLL_LOCK_DELAY_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int INTERNAL_OSC_STABILISE_CYCLES =
    (INTERNAL_OSC_STABILISE_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

  // ==========================================================================
  // Counter widths.
  // ==========================================================================
  localparam int OSC_COUNT_W = 13;
  localparam int PREPARE_COUNT_W = 9;
  localparam int STABILISE_COUNT_W = 6;

  localparam logic [OSC_COUNT_W-1:0] OSC_ONLY_LOAD = OSC_COUNT_W'(OSC_STARTUP_CYCLES);
  localparam logic [OSC_COUNT_W-1:0] OSC_PLL_LOAD =
    OSC_COUNT_W'(OSC_STARTUP_CYCLES + PLL_LOCK_CYCLES);
  localparam logic [PREPARE_COUNT_W-1:0] PREPARE_LOAD = PREPARE_COUNT_W'(CPU_PREPARE_CYCLES);
  localparam logic [STABILISE_COUNT_W-1:0] STABILISE_LOAD =
    STABILISE_COUNT_W'(INTERNAL_OSC_STABILISE_CYCLES);

  // ==========================================================================
  // Internal oscillator frequency selection.
  // ==========================================================================
  localparam logic [2:0] INTERNAL_OSC_FREQ_1MHZ = 3'h4;
  localparam logic [2:0] INTERNAL_OSC_FREQ_8MHZ = 3'h7;

  // ==========================================================================
  // Clock source before wake-up and primary oscillator configuration.
  // ==========================================================================
  typedef enum logic [1:0] {
    SRC_PRIMARY_IDLE = 2'h0,
    SRC_SECONDARY = 2'h1,
    SRC_INTERNAL = 2'h2,
    SRC_NONE_SLEEP = 2'h3
  } prior_source_t;

  typedef enum logic [2:0] {
    LOW_POWER_CRYSTAL_MODE = 3'h0,
    STANDARD_CRYSTAL_MODE = 3'h1,
    HIGH_SPEED_CRYSTAL_MODE = 3'h2,
    HIGH_SPEED_CRYSTAL_PLL_MODE = 3'h3,
    EXTERNAL_CLOCK_MODE = 3'h4,
    RESISTOR_CAPACITOR_OSC_MODE = 3'h5,
    INTERNAL_OSC_IO_MODE = 3'h6
  } target_mode_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALTED,
    ST_WAKING
  } seq_state_t;

endpackage : wake_exit_pkg

//--- sim/wake_exit_properties.sv
// Assertions on the ports of the wake exit delay sequencer.
`timescale 1ns/1ps
module wake_exit_properties
  import wake_exit_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic sleep_enter_in,
  input wire logic wake_in,
  input wire logic [1:0] prior_source_in,
  input wire logic [2:0] target_mode_in,
  input wire logic freq_sel_write_in,
  input wire logic [2:0] freq_sel_in,
  input wire logic cpu_run_out,
  input wire logic startup_timer_done_flag_out,
  input wire logic internal_osc_stable_flag_out,
  input wire logic [2:0] internal_osc_freq_sel_out
);
  localparam logic [13:0] PREP = 14'(CPU_PREPARE_CYCLES);
  logic waking;
  logic [13:0] cnt;
  logic [13:0] exp_n;
  logic [13:0] timer_end;
  wire take = wake_in && !cpu_run_out && !waking;
  wire io_late = take && target_mode_in == 3'h6 && prior_source_in[0];
  wire io_now = take && target_mode_in == 3'h6 && !prior_source_in[0];
  wire [13:0] timer_calc = prior_source_in == 2'h0 ? 14'h0 :
    target_mode_in <= 3'h2 ? 14'(OSC_STARTUP_CYCLES) :
    target_mode_in == 3'h3 ? 14'(OSC_STARTUP_CYCLES + PLL_LOCK_CYCLES) : 14'h0;

  // Counts edges since the accepted wake; cnt equals k at the k-th edge after it.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      waking <= 1'b0;
      cnt <= 14'h0;
      exp_n <= 14'h0;
      timer_end <= 14'h0;
    end else if (take) begin
      waking <= 1'b1;
      cnt <= 14'h1;
      exp_n <= timer_calc > PREP ? timer_calc : PREP;
      timer_end <= timer_calc;
    end else if (waking) begin
      cnt <= cnt + 14'h1;
      waking <= !cpu_run_out;
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_sleep_stalls_cpu: assert property (
    sleep_enter_in && cpu_run_out |=> !cpu_run_out)
    else $error("cpu kept running after sleep entry");
  a_no_early_run: assert property (
    waking && cnt < exp_n |=> !cpu_run_out)
    else $error("cpu released before the longest delay");
  a_run_on_time: assert property (
    waking && cnt == exp_n |=> cpu_run_out)
    else $error("cpu not released when the delay ended");
  a_timer_flag_low: assert property (
    waking && timer_end != 14'h0 && cnt > 14'h1 && cnt <= timer_end
    |-> !startup_timer_done_flag_out)
    else $error("start-up flag set too early");
  a_timer_flag_set: assert property (
    waking && timer_end != 14'h0 && cnt == timer_end + 14'h1
    |-> startup_timer_done_flag_out)
    else $error("start-up flag not set at timer end");
  a_iosc_flag_late: assert property (
    io_late |-> ##2 !internal_osc_stable_flag_out ##38
    !internal_osc_stable_flag_out ##1 internal_osc_stable_flag_out)
    else $error("stable flag timing wrong");
  a_iosc_flag_now: assert property (
    io_now |-> ##2 internal_osc_stable_flag_out)
    else $error("stable flag not set at once");
  a_freq_write: assert property (
    freq_sel_write_in |=> internal_osc_freq_sel_out == $past(freq_sel_in))
    else $error("frequency select not loaded");

  cover property (take && timer_calc > PREP && target_mode_in == 3'h3);
  cover property (io_late);
  cover property (take && prior_source_in == 2'h0);
endmodule : wake_exit_properties

//--- sim/wake_source_model.sv
// Wake source and stall timer standing in for the clock sources and the CPU core.
`timescale 1ns/1ps
module wake_source_model (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic cpu_run_in,
  input wire logic fire_in,
  input wire logic [4:0] cfg_in,
  output logic wake_out,
  output logic [4:0] cfg_out,
  output logic [13:0] stall_out
);
  // The clock configuration stays put until the next wake, as a real strap would.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wake_out <= 1'b0;
      cfg_out <= 5'h0;
      stall_out <= 14'h0;
    end else begin
      wake_out <= fire_in;
      if (fire_in) cfg_out <= cfg_in;
      if (wake_out) stall_out <= 14'h0;
      else if (!cpu_run_in) stall_out <= stall_out + 14'h1;
    end
  end
endmodule : wake_source_model

//--- sim/testbench.sv
// Self-checking testbench for the wake exit delay sequencer.
`timescale 1ns/1ps
`define CHECK(got, want) begin total_checks++; if ((got) !== (want)) begin n_fail++; \
  $display("unexpected at %0t: got %0h want %0h", $time, got, want); end end
module testbench
  import wake_exit_pkg::*;
;
  logic clk, rst_b, sleep, fire, fwr, wake, run, st_done, io_ok;
  logic [4:0] cfg, cfg_q;
  logic [2:0] fsel, fout;
  logic [13:0] stall;
  int n_fail = 0, total_checks = 0, seed = 32'hF86F1926, n;

  wake_source_model wake_source_model_i (.core_clk_in(clk), .rst_b_in(rst_b), .cpu_run_in(run),
    .fire_in(fire), .cfg_in(cfg), .wake_out(wake), .cfg_out(cfg_q), .stall_out(stall));
  wake_exit_delay_sequencer wake_exit_delay_sequencer_i (.core_clk_in(clk), .rst_b_in(rst_b),
    .sleep_enter_in(sleep), .wake_in(wake), .prior_source_in(cfg_q[4:3]),
    .target_mode_in(cfg_q[2:0]), .freq_sel_write_in(fwr), .freq_sel_in(fsel), .cpu_run_out(run),
    .startup_timer_done_flag_out(st_done), .internal_osc_stable_flag_out(io_ok),
    .internal_osc_freq_sel_out(fout));

  function automatic int expect_stall(logic [4:0] c);
    int o = 0;
    if (c[4:3] != 2'h0 && c[2:0] <= 3'h2) o = OSC_STARTUP_CYCLES;
    if (c[4:3] != 2'h0 && c[2:0] == 3'h3) o = OSC_STARTUP_CYCLES + PLL_LOCK_CYCLES;
    return o > CPU_PREPARE_CYCLES ? o : CPU_PREPARE_CYCLES;
  endfunction : expect_stall

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic run_case(logic [4:0] c);
    @(posedge clk) sleep <= 1'b1;
    fwr <= 1'b1;
    fsel <= 3'($random(seed));
    @(posedge clk) sleep <= 1'b0;
    fwr <= 1'b0;
    @(posedge clk) #1;
    `CHECK(run, 1'b0)
    `CHECK(fout, fsel)
    repeat (2 + $unsigned($random(seed)) % 8) @(posedge clk);
    @(posedge clk) fire <= 1'b1;
    cfg <= c;
    @(posedge clk) fire <= 1'b0;
    for (n = 0; n < 6000 && run !== 1'b1; n++) @(posedge clk) #1;
    if (n == 6000) begin
      n_fail++;
      give_verdict;
    end
    `CHECK(stall, 14'(expect_stall(c)))
    if (c[2:0] <= 3'h3) `CHECK(st_done, 1'b1)
    if (c[2:0] == 3'h6) `CHECK(io_ok, 1'b1)
  endtask : run_case

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {rst_b, sleep, fire, fwr} = 4'h0;
    cfg = 5'h0;
    fsel = 3'h0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk) #1;
    `CHECK(fout, INTERNAL_OSC_FREQ_1MHZ)
    `CHECK({run, st_done, io_ok}, 3'h4)
    for (int i = 0; i < 34; i++) begin
      if (i < 28) run_case({2'(i / 7), 3'(i % 7)});
      else run_case({2'($random(seed)), 3'($unsigned($random(seed)) % 7)});
    end
    @(posedge clk) fire <= 1'b1;
    @(posedge clk) fire <= 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHECK(run, 1'b1)
    @(posedge clk) sleep <= 1'b1;
    @(posedge clk) sleep <= 1'b0;
    fire <= 1'b1;
    cfg <= 5'h0B;
    @(posedge clk) fire <= 1'b0;
    repeat (50) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHECK({run, st_done, io_ok, fout}, 6'h24)
    @(posedge clk) rst_b <= 1'b1;
    run_case(5'h1E);
    give_verdict;
  end
endmodule : testbench

bind wake_exit_delay_sequencer wake_exit_properties wake_exit_properties_i (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .sleep_enter_in(sleep_enter_in),
  .wake_in(wake_in), .prior_source_in(prior_source_in), .target_mode_in(target_mode_in),
  .freq_sel_write_in(freq_sel_write_in), .freq_sel_in(freq_sel_in), .cpu_run_out(cpu_run_out),
  .startup_timer_done_flag_out(startup_timer_done_flag_out),
  .internal_osc_stable_flag_out(internal_osc_stable_flag_out),
  .internal_osc_freq_sel_out(internal_osc_freq_sel_out));
